// File: hw/lcdm_four_mux_drv.v
// four-common multiplexed segment lcd waveform generator, with static drive option
`timescale 1ns/100ps
`include "lcdm_regs.vh"

module lcdm_four_mux_drv (
    // clock and asynchronous reset
    input  wire        REF_CLK,
    input  wire        RESETN,
    // host controls, asynchronous to REF_CLK
    input  wire        SYNC_RESET_N,
    input  wire        STATIC_MODE,
    // pattern bytes, byte k at bits 8k+7:8k, held stable by the host
    input  wire [63:0] PATTERN_BYTES,
    // common lines: readback, level and drive enable
    input  wire [3:0]  COMMON_LINE_I,
    output wire [3:0]  COMMON_LINE_O,
    output wire [3:0]  COMMON_LINE_OE,
    // segment lines, always push-pull
    output wire [7:0]  SEGMENT_LINE,
    // status
    output wire [2:0]  PATTERN_STATE,
    output wire        DRIVE_FAULT
);

    localparam [`LCDM_DIV_WIDTH-1:0] TICK_LAST = `LCDM_TICK_LAST;

    // synchronised host controls
    wire        sync_reset_n;
    wire        static_mode;
    wire [3:0]  common_line_in;
    wire [63:0] pattern_bytes;

    // tick divider and phase counter
    reg  [`LCDM_DIV_WIDTH-1:0]   div_reg;
    reg  [`LCDM_DIV_WIDTH-1:0]   div_next;
    reg  [`LCDM_STATE_WIDTH-1:0] phase_reg;
    reg  [`LCDM_STATE_WIDTH-1:0] phase_next;
    wire                         tick;

    // decoded phase fields
    wire       frame_half;
    wire [1:0] slot;
    wire [7:0] state_byte;

    // output registers
    reg  [3:0] common_o_reg;
    reg  [3:0] common_o_next;
    reg  [3:0] common_oe_reg;
    reg  [3:0] common_oe_next;
    reg  [7:0] segment_reg;
    reg  [7:0] segment_next;

    // readback checker
    reg  [1:0] settle_reg;
    reg  [1:0] settle_next;
    reg        fault_reg;
    reg        fault_next;
    wire       drive_changed;
    wire       mismatch;

    // host levels cross into REF_CLK; sync reset starts held low
    lcdm_sync2 #(
        .WIDTH    (2),
        .INIT_VAL (2'h0)
    ) u_sync_ctrl (
        .clk      (REF_CLK),
        .rst_n    (RESETN),
        .async_in ({SYNC_RESET_N, STATIC_MODE}),
        .sync_out ({sync_reset_n, static_mode})
    );

    // pad levels of the commons, used only for the drive check
    lcdm_sync2 #(
        .WIDTH    (4),
        .INIT_VAL (4'h0)
    ) u_sync_common (
        .clk      (REF_CLK),
        .rst_n    (RESETN),
        .async_in (COMMON_LINE_I),
        .sync_out (common_line_in)
    );

    // pattern bytes change only while the waveform is held; syncing them keeps
    // a late host write from reaching the segments half-settled
    lcdm_sync2 #(
        .WIDTH    (64),
        .INIT_VAL (64'h0000_0000_0000_0000)
    ) u_sync_pattern (
        .clk      (REF_CLK),
        .rst_n    (RESETN),
        .async_in (PATTERN_BYTES),
        .sync_out (pattern_bytes)
    );

    // divider makes one oscillator tick every 2000 reference cycles
    assign tick = (div_reg == TICK_LAST);

    // divider and phase restart together while sync reset is low
    always @* begin
        div_next   = div_reg;
        phase_next = phase_reg;
        if (!sync_reset_n) begin
            div_next   = {`LCDM_DIV_WIDTH{1'b0}};
            phase_next = `LCDM_RST_STATE;
        end else if (tick) begin
            div_next   = {`LCDM_DIV_WIDTH{1'b0}};
            phase_next = phase_reg + 3'h1;
        end else begin
            div_next   = div_reg + {{(`LCDM_DIV_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_reg   <= {`LCDM_DIV_WIDTH{1'b0}};
            phase_reg <= `LCDM_RST_STATE;
        end else begin
            div_reg   <= div_next;
            phase_reg <= phase_next;
        end
    end

    // slot picks the common, half picks the polarity; both from one counter
    assign frame_half = phase_reg[`LCDM_STATE_HALF_BIT];
    assign slot       = phase_reg[`LCDM_STATE_SLOT_MSB:0];

    // byte of the current pattern state; host stores the inverted half in 4..7
    assign state_byte = pattern_bytes[{phase_reg, 3'h0} +: 8];

    // next drive of commons and segments
    always @* begin : drive_calc
        integer n;
        n              = 0;
        common_o_next  = `LCDM_RST_COMMON_O;
        common_oe_next = `LCDM_RST_COMMON_OE;
        segment_next   = `LCDM_RST_SEGMENT;
        if (!sync_reset_n) begin
            // held: commons float at mid level, segments low
            common_o_next  = `LCDM_RST_COMMON_O;
            common_oe_next = `LCDM_RST_COMMON_OE;
            segment_next   = `LCDM_RST_SEGMENT;
        end else if (static_mode) begin
            // single common is a push-pull square wave, toggling each half frame
            common_oe_next[0] = 1'b1;
            common_o_next[0]  = frame_half;
            // a zero bit in byte 0 lights that segment by inverting the wave
            segment_next = {8{frame_half}} ^ ~pattern_bytes[7:0];
        end else begin
            for (n = 0; n < `LCDM_NUM_COMMON; n = n + 1) begin
                if (slot == n[1:0]) begin
                    // active slot: driven to a rail, low then high
                    common_oe_next[n] = 1'b1;
                    common_o_next[n]  = frame_half;
                end else begin
                    // idle slot: released so the divider holds it at mid level
                    common_oe_next[n] = 1'b0;
                    common_o_next[n]  = 1'b0;
                end
            end
            // rail against rail lights a pair, rail against mid never does
            segment_next = state_byte;
        end
    end

    // outputs all move on the same edge so commons and segments stay aligned
    always @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            common_o_reg  <= `LCDM_RST_COMMON_O;
            common_oe_reg <= `LCDM_RST_COMMON_OE;
            segment_reg   <= `LCDM_RST_SEGMENT;
        end else begin
            common_o_reg  <= common_o_next;
            common_oe_reg <= common_oe_next;
            segment_reg   <= segment_next;
        end
    end

    // readback is only meaningful once a driven level has crossed the synchroniser
    assign drive_changed = (common_o_next != common_o_reg) ||
                           (common_oe_next != common_oe_reg);
    assign mismatch      = |(common_oe_reg & (common_o_reg ^ common_line_in));

    // sticky fault: a driven common reads back the wrong level; a short or
    // a divider too stiff for the pad shows up here, cleared by sync reset
    always @* begin
        settle_next = settle_reg;
        fault_next  = fault_reg;
        if (!sync_reset_n) begin
            settle_next = 2'h0;
            fault_next  = 1'b0;
        end else begin
            if (drive_changed) begin
                settle_next = 2'h0;
            end else if (settle_reg != `LCDM_SETTLE_CYCLES) begin
                settle_next = settle_reg + 2'h1;
            end
            if ((settle_reg == `LCDM_SETTLE_CYCLES) && mismatch) begin
                fault_next = 1'b1;
            end
        end
    end

    always @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            settle_reg <= 2'h0;
            fault_reg  <= 1'b0;
        end else begin
            settle_reg <= settle_next;
            fault_reg  <= fault_next;
        end
    end

    // port drive
    assign COMMON_LINE_O  = common_o_reg;
    assign COMMON_LINE_OE = common_oe_reg;
    assign SEGMENT_LINE   = segment_reg;
    assign PATTERN_STATE  = phase_reg;
    assign DRIVE_FAULT    = fault_reg;

endmodule

// File: hw/lcdm_regs.vh
// timing, size and reset constants for the four-common lcd waveform generator
`ifndef LCDM_REGS_VH
`define LCDM_REGS_VH

// reference clock: 50 MHz, period in ns
`define LCDM_REF_CLK_PERIOD_NS  20
// oscillator tick that paces the drive waveforms: 25 kHz, period in ns
`define LCDM_OSC_PERIOD_NS      40000
// reference clock cycles per oscillator tick (2000)
`define LCDM_TICK_CYCLES        (`LCDM_OSC_PERIOD_NS / `LCDM_REF_CLK_PERIOD_NS)
// width of the tick divider counter
`define LCDM_DIV_WIDTH          11
// last divider count, one below the cycles per tick (1999)
`define LCDM_TICK_LAST          11'h7cf

// line counts
`define LCDM_NUM_COMMON         4
`define LCDM_NUM_SEGMENT        8
`define LCDM_NUM_STATES         8

// pattern state field positions: slot is bits 1:0, frame half is bit 2
`define LCDM_STATE_WIDTH        3
`define LCDM_STATE_HALF_BIT     2
`define LCDM_STATE_SLOT_MSB     1

// cycles a driven common must hold before its readback is trusted
`define LCDM_SETTLE_CYCLES      2'h3

// reset values
`define LCDM_RST_STATE          3'h0
`define LCDM_RST_SEGMENT        8'h00
`define LCDM_RST_COMMON_O       4'h0
`define LCDM_RST_COMMON_OE      4'h0

`endif

// File: hw/lcdm_sync2.v
// two-flip-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/100ps

module lcdm_sync2 #(
    parameter               WIDTH    = 1,
    parameter [WIDTH-1:0]   INIT_VAL = {WIDTH{1'b0}}
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // asynchronous level in, synchronised level out
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // first stage feeds only the second stage
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= INIT_VAL;
            sync_reg <= INIT_VAL;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

// File: testbench/lcdm_drv_sva.sv
// assertion checker for the four-common lcd waveform generator
`timescale 1ns/100ps
module lcdm_drv_chk (
    // clock and reset
    input wire        REF_CLK,
    input wire        RESETN,
    // host side
    input wire        SYNC_RESET_N,
    input wire        STATIC_MODE,
    input wire [63:0] PATTERN_BYTES,
    // glass side and status
    input wire [3:0]  COMMON_LINE_I,
    input wire [3:0]  COMMON_LINE_O,
    input wire [3:0]  COMMON_LINE_OE,
    input wire [7:0]  SEGMENT_LINE,
    input wire [2:0]  PATTERN_STATE,
    input wire        DRIVE_FAULT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    logic [2:0]  last_reg;
    logic [11:0] run_reg;
    wire         drv  = |COMMON_LINE_OE;
    wire [1:0]   slot = PATTERN_STATE[1:0];
    wire         half = PATTERN_STATE[2];
    wire [7:0]   lo_byte = PATTERN_BYTES[7:0];
    wire [7:0]   cur_byte = PATTERN_BYTES[PATTERN_STATE*8 +: 8];
    // run length of each phase value, so a short or stretched state shows up
    always @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            last_reg <= 3'h0;
            run_reg  <= 12'h000;
        end else begin
            last_reg <= PATTERN_STATE;
            run_reg  <= (PATTERN_STATE != last_reg) ? 12'h001 : run_reg + 12'h001;
        end
    end
    a_one_common: assert property ($onehot0(COMMON_LINE_OE))
        else $error("more than one common driven");
    a_slot_owner: assert property ((drv && !STATIC_MODE) |->
        COMMON_LINE_OE == (4'h1 << $past(slot))) else $error("wrong common driven");
    a_common_level: assert property (drv |->
        COMMON_LINE_O == (COMMON_LINE_OE & {4{$past(half)}})) else $error("common level");
    a_mux_segment: assert property ((drv && !STATIC_MODE) |->
        SEGMENT_LINE == $past(cur_byte)) else $error("segment byte");
    a_static_seg: assert property ((drv && STATIC_MODE) |-> COMMON_LINE_OE == 4'h1 &&
        SEGMENT_LINE == ({8{$past(half)}} ^ ~$past(lo_byte))) else $error("static drive");
    a_state_step: assert property ((PATTERN_STATE != last_reg && PATTERN_STATE > 3'h1) |->
        PATTERN_STATE == last_reg + 3'h1 && run_reg == 12'h7d0) else $error("phase step");
    a_quiet_reset: assert property (!SYNC_RESET_N [*4] |=>
        COMMON_LINE_OE == 4'h0 && SEGMENT_LINE == 8'h00 && !DRIVE_FAULT) else $error("reset");
    a_undriven_low: assert property ((COMMON_LINE_O & ~COMMON_LINE_OE) == 4'h0)
        else $error("undriven common not low");
    c_last_state: cover property (PATTERN_STATE == 3'h7 && !STATIC_MODE);
    c_static_high: cover property (STATIC_MODE && COMMON_LINE_O[0]);
    c_fault: cover property ($rose(DRIVE_FAULT));
endmodule
bind lcdm_four_mux_drv lcdm_drv_chk u_chk (.REF_CLK(REF_CLK), .RESETN(RESETN),
    .SYNC_RESET_N(SYNC_RESET_N), .STATIC_MODE(STATIC_MODE), .PATTERN_BYTES(PATTERN_BYTES),
    .COMMON_LINE_I(COMMON_LINE_I), .COMMON_LINE_O(COMMON_LINE_O),
    .COMMON_LINE_OE(COMMON_LINE_OE), .SEGMENT_LINE(SEGMENT_LINE),
    .PATTERN_STATE(PATTERN_STATE), .DRIVE_FAULT(DRIVE_FAULT));

// File: testbench/lcdm_four_mux_drv_test.sv
// self-checking bench for the four-common lcd waveform generator
`timescale 1ns/100ps
module lcdm_four_mux_drv_test;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        sync_n = 1'b0;
    logic        stat = 1'b0;
    logic        short0 = 1'b0;
    logic [63:0] bytes = 64'h0000_0000_0000_0000;
    logic [31:0] half = 32'hefb7_bbfd;
    wire  [3:0]  com_i, com_o, com_oe;
    wire  [7:0]  seg;
    wire  [2:0]  state;
    wire         fault;
    wire  [31:0] lit;
    int          mismatches = 0;
    int          compares = 0;
    always #10 ref_clk = ~ref_clk;
    lcdm_four_mux_drv DUT (.REF_CLK(ref_clk), .RESETN(resetn), .SYNC_RESET_N(sync_n),
        .STATIC_MODE(stat), .PATTERN_BYTES(bytes), .COMMON_LINE_I(com_i),
        .COMMON_LINE_O(com_o), .COMMON_LINE_OE(com_oe), .SEGMENT_LINE(seg),
        .PATTERN_STATE(state), .DRIVE_FAULT(fault));
    lcdm_glass_model u_glass (.clk(ref_clk), .common_o(com_o), .common_oe(com_oe),
        .segment(seg), .short_com0(short0), .common_i(com_i), .lit(lit));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // bounded wait for a phase, then let the registered outputs follow
    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        while (state !== s && n < 24000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 24000) begin
            mismatches++;
            $display("ERROR at %0t: phase %0d not reached", $time, s);
            stop_test();
        end
        repeat (3) @(negedge ref_clk);
    endtask
    // patterns only change while the waveform is held
    task automatic restart(input logic mode, input logic [63:0] b);
        sync_n = 1'b0;
        repeat (5) @(negedge ref_clk);
        stat  = mode;
        bytes = b;
        repeat (5) @(negedge ref_clk);
        check(com_oe, 4'h0);
        sync_n = 1'b1;
    endtask
    task automatic test_mux;
        logic [31:0] exp_lit;
        time         t1;
        for (int k = 0; k < 32; k++) exp_lit[k] = half[8*(k%4) + k/4];
        restart(1'b0, {~half, half});
        for (int s = 0; s < 8; s++) begin
            wait_state(s[2:0]);
            if (s == 1) t1 = $time;
            if (s == 2) check(($time - t1) / 20, 2000);
            check(com_oe, 4'h1 << s[1:0]);
            check(com_o, s[2] ? 4'h1 << s[1:0] : 4'h0);
            check(seg, half[8*(s%4) +: 8] ^ {8{s[2]}});
            if (s % 4 == 3) check(lit, exp_lit);
        end
        check(fault, 1'b0);
        $display("mux test done");
    endtask
    task automatic test_static;
        restart(1'b1, 64'h0000_0000_0000_005a);
        for (int s = 0; s < 8; s += 4) begin
            wait_state(s[2:0]);
            check(com_oe, 4'h1);
            check(com_o, {3'h0, s[2]});
            check(seg, {8{s[2]}} ^ 8'ha5);
        end
        $display("static test done");
    endtask
    task automatic test_fault;
        short0 = 1'b1;
        restart(1'b0, {~half, half});
        repeat (12) @(negedge ref_clk);
        check(fault, 1'b1);
        short0 = 1'b0;
        restart(1'b0, {~half, half});
        check(fault, 1'b0);
        repeat (12) @(negedge ref_clk);
        check(fault, 1'b0);
        $display("fault test done");
    endtask
    initial begin
        repeat (20) @(negedge ref_clk);
        check(com_oe, 4'h0);
        resetn = 1'b1;
        test_mux();
        test_static();
        test_fault();
        stop_test();
    end
endmodule

// File: testbench/lcdm_glass_model.sv
// four-common segment glass with a mid-level divider on every common
`timescale 1ns/100ps
module lcdm_glass_model (
    // clock
    input wire         clk,
    // drive reaching the glass
    input wire  [3:0]  common_o,
    input wire  [3:0]  common_oe,
    input wire  [7:0]  segment,
    // fault: common 0 shorted to the supply
    input wire         short_com0,
    // pad readback and lit map, bit 4*segment+common
    output logic [3:0]  common_i,
    output logic [31:0] lit
);
    logic mid_reg = 1'b0;
    // the divider mid level reads as neither rail, so it wanders every cycle
    always @(posedge clk) mid_reg <= ~mid_reg;
    always_comb begin
        for (int c = 0; c < 4; c++)
            common_i[c] = common_oe[c] ? common_o[c] : mid_reg;
        if (short_com0)
            common_i[0] = 1'b1;
    end
    // full-rail difference on a driven common lights a pair, an undriven common leaves its pairs unchanged
    always @(posedge clk)
        for (int k = 0; k < 32; k++)
            if (common_oe[k%4]) lit[k] <= segment[k/4] ^ common_o[k%4];
endmodule
